// ===== rtl/cac_pkg.sv
// package: register layout and source codes for the counter array control block
package cac_pkg;
  // counter_control bit positions
  localparam int CTL_FLAG_LSB   = 0;
  localparam int CTL_FLAG_MSB   = 2;
  localparam int CTL_RUN_BIT    = 6;
  localparam int CTL_OVF_BIT    = 7;
  // counter_mode bit positions
  localparam int MODE_OVFIE_BIT = 0;
  localparam int MODE_SRC_LSB   = 1;
  localparam int MODE_SRC_MSB   = 3;
  localparam int MODE_IDLE_BIT  = 7;
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int NUM_MODULES = 3;
  localparam int CNT_WIDTH   = 16;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [2:0] DIV8_LAST  = 3'h7;
  typedef enum logic [2:0] {
    SRC_DIV12  = 3'h0,
    SRC_DIV4   = 3'h1,
    SRC_T0OVF  = 3'h2,
    SRC_EXTIN  = 3'h3,
    SRC_SYSCLK = 3'h4,
    SRC_EXTDIV = 3'h5
  } cac_src_type;
endpackage

// ===== rtl/cac_core.sv
// counter array control: run bit, match flags, overflow flag, count source, shared counter
//
// Summary of operation
// - counter holds while run bit is 0, advances per selected event when 1
// - control register bits 5..3 read zero; writes to them do nothing
// - hardware sets module n match flag on compare match or capture of module n
// - enabled set match flag raises the shared interrupt request
// - match flags never self-clear; only a software write clears them
// - overflow sets overflow flag, raising interrupt if enabled; software clears it
`timescale 1ns/100ps
module cac_core #(
  parameter int NMOD = cac_pkg::NUM_MODULES,
  parameter int CW   = cac_pkg::CNT_WIDTH
) (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst_n,
  // special function register access
  input  wire logic            ctl_wr,
  input  wire logic            mode_wr,
  input  wire logic [7:0]      wr_data,
  output logic      [7:0]      counter_control,
  output logic      [7:0]      counter_mode,
  // module events and interrupt enables
  input  wire logic [NMOD-1:0] module_event,
  input  wire logic [NMOD-1:0] module_irq_enable,
  output logic                 counter_array_irq,
  // count sources
  input  wire logic            timer0_overflow,
  input  wire logic            external_count_input,
  input  wire logic            external_clock,
  // shared counter
  output logic      [CW-1:0]   counter_value,
  output logic                 count_tick
);
  logic [NMOD-1:0] flags_r, flags_nxt;
  logic            run_r, run_nxt, ovf_r, ovf_nxt;
  logic            idle_r, idle_nxt, ovfie_r, ovfie_nxt;
  logic [2:0]      src_r, src_nxt;
  logic [CW-1:0]   cnt_r, cnt_nxt;
  logic            tick_r, tick_nxt, irq_r, irq_nxt;
  logic [3:0]      div12_r, div12_nxt;
  logic [1:0]      div4_r, div4_nxt;
  logic [2:0]      div8_r, div8_nxt;
  // pin synchronisers; third stage only feeds edge detection
  logic [2:0]      eci_sync_r, ecl_sync_r;
  logic            event_now;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eci_sync_r <= 3'h7;
      ecl_sync_r <= 3'h0;
    end else begin
      eci_sync_r <= {eci_sync_r[1:0], external_count_input};
      ecl_sync_r <= {ecl_sync_r[1:0], external_clock};
    end
  end

  always_comb begin
    div12_nxt = (div12_r == cac_pkg::DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
    div4_nxt  = div4_r + 2'h1;
    div8_nxt  = div8_r;
    if (ecl_sync_r[1] && !ecl_sync_r[2]) begin
      div8_nxt = div8_r + 3'h1;
    end
    case (cac_pkg::cac_src_type'(src_r))
      cac_pkg::SRC_DIV12:  event_now = (div12_r == cac_pkg::DIV12_LAST);
      cac_pkg::SRC_DIV4:   event_now = (div4_r == cac_pkg::DIV4_LAST);
      cac_pkg::SRC_T0OVF:  event_now = timer0_overflow;
      cac_pkg::SRC_EXTIN:  event_now = eci_sync_r[2] && !eci_sync_r[1];
      cac_pkg::SRC_SYSCLK: event_now = 1'b1;
      cac_pkg::SRC_EXTDIV: event_now = (div8_r == cac_pkg::DIV8_LAST)
                                       && ecl_sync_r[1] && !ecl_sync_r[2];
      default:             event_now = 1'b0; // reserved codes never count
    endcase
    tick_nxt = run_r && event_now;
    cnt_nxt  = tick_nxt ? cnt_r + {{(CW-1){1'b0}}, 1'b1} : cnt_r;
    // software write first, hardware set after so a coincident event wins
    run_nxt   = ctl_wr ? wr_data[cac_pkg::CTL_RUN_BIT] : run_r;
    flags_nxt = ctl_wr ? wr_data[cac_pkg::CTL_FLAG_MSB:cac_pkg::CTL_FLAG_LSB] : flags_r;
    flags_nxt = flags_nxt | module_event;
    ovf_nxt   = ctl_wr ? wr_data[cac_pkg::CTL_OVF_BIT] : ovf_r;
    if (tick_nxt && (cnt_r == {CW{1'b1}})) begin
      ovf_nxt = 1'b1;
    end
    idle_nxt  = mode_wr ? wr_data[cac_pkg::MODE_IDLE_BIT] : idle_r;
    src_nxt   = mode_wr ? wr_data[cac_pkg::MODE_SRC_MSB:cac_pkg::MODE_SRC_LSB] : src_r;
    ovfie_nxt = mode_wr ? wr_data[cac_pkg::MODE_OVFIE_BIT] : ovfie_r;
    irq_nxt   = |(flags_nxt & module_irq_enable) || (ovf_nxt && ovfie_nxt);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= '0;
      run_r   <= 1'b0;
      ovf_r   <= 1'b0;
      idle_r  <= 1'b0;
      src_r   <= 3'h0;
      ovfie_r <= 1'b0;
      cnt_r   <= '0;
      tick_r  <= 1'b0;
      irq_r   <= 1'b0;
      div12_r <= 4'h0;
      div4_r  <= 2'h0;
      div8_r  <= 3'h0;
    end else begin
      flags_r <= flags_nxt;
      run_r   <= run_nxt;
      ovf_r   <= ovf_nxt;
      idle_r  <= idle_nxt;
      src_r   <= src_nxt;
      ovfie_r <= ovfie_nxt;
      cnt_r   <= cnt_nxt;
      tick_r  <= tick_nxt;
      irq_r   <= irq_nxt;
      div12_r <= div12_nxt;
      div4_r  <= div4_nxt;
      div8_r  <= div8_nxt;
    end
  end

  // reserved bits are constant zero in both registers
  assign counter_control   = {ovf_r, run_r, 3'h0, flags_r};
  assign counter_mode      = {idle_r, 3'h0, src_r, ovfie_r};
  assign counter_array_irq = irq_r;
  assign counter_value     = cnt_r;
  assign count_tick        = tick_r;
endmodule

// ===== verif/cac_core_monitor.sv
// checker: port timing relations of the counter array control block
`timescale 1ns/100ps
module cac_core_monitor #(
  parameter int NMOD = 3
) (
  // clock, reset and controls
  input logic            core_clk, rst_n, ctl_wr, counter_array_irq, count_tick,
  // readback and events
  input logic [7:0]      counter_control, counter_mode,
  input logic [NMOD-1:0] module_event, module_irq_enable,
  input logic [15:0]     counter_value
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ctl_rsvd: assert property (counter_control[5:3] == 3'h0) else $error("ctl 5:3");
  a_mode_rsvd: assert property (counter_mode[6:4] == 3'h0) else $error("mode 6:4");
  a_tick_adds: assert property (count_tick |-> counter_value == $past(counter_value) + 16'h1)
    else $error("tick step");
  a_stop_hold: assert property (!counter_control[6] ##1 !counter_control[6]
    |-> $stable(counter_value)) else $error("stopped count moved");
  a_evt_sets: assert property (|module_event |=>
    (counter_control[2:0] & $past(module_event)) == $past(module_event)) else $error("flag set");
  a_flag_keep: assert property (!ctl_wr |=>
    (counter_control[2:0] & $past(counter_control[2:0])) == $past(counter_control[2:0]))
    else $error("flag lost");
  a_ovf_keep: assert property (counter_control[7] && !ctl_wr |=> counter_control[7])
    else $error("ovf lost");
  a_irq_flags: assert property (|(counter_control[2:0] & module_irq_enable)
    && $stable(module_irq_enable) |-> counter_array_irq) else $error("irq missing");
endmodule
bind cac_core cac_core_monitor #(.NMOD(NMOD)) i_cac_core_monitor (.*);

// ===== verif/tb_top.sv
// testbench: register, flag, count source and overflow scenarios
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 0, rst_n = 0, ctl_wr = 0, mode_wr = 0, timer0_overflow = 0;
  // count input idles high, matching the synchroniser's reset level
  logic external_count_input = 1, external_clock = 0, counter_array_irq, count_tick;
  logic [7:0]  wr_data = 0, counter_control, counter_mode;
  logic [2:0]  module_event = 0, module_irq_enable = 0;
  logic [15:0] counter_value, v;
  int          num_errors = 0, checks = 0;
  cac_core i_cac_core (.*);
  initial forever #50 core_clk = ~core_clk;
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // one write, then an edge so readback has landed
  task automatic wr(logic c, logic [7:0] d);
    @(posedge core_clk);
    ctl_wr <= c;
    mode_wr <= !c;
    wr_data <= d;
    @(posedge core_clk);
    ctl_wr <= 0;
    mode_wr <= 0;
    #1;
  endtask
  task automatic t_regs;
    wr(1, 8'h78);
    chk("ctl", 8'h40, counter_control);
    wr(0, 8'h79);
    chk("mode", 8'h09, counter_mode);
    v = counter_value;
    repeat (10) @(posedge core_clk);
    #1 chk("run", v + 16'hA, counter_value);
    wr(1, 8'h00);
    v = counter_value;
    repeat (10) @(posedge core_clk);
    #1 chk("stop", v, counter_value);
  endtask
  task automatic t_flags;
    @(posedge core_clk);
    module_irq_enable <= 3'h2;
    module_event <= 3'h6;
    @(posedge core_clk);
    module_event <= 3'h0;
    repeat (5) @(posedge core_clk);
    #1 chk("flags", 3'h6, counter_control[2:0]);
    chk("irq", 1, counter_array_irq);
    @(posedge core_clk);
    module_irq_enable <= 3'h1;
    repeat (2) @(posedge core_clk);
    #1 chk("mask", 0, counter_array_irq);
    wr(1, 8'h00);
    chk("clr", 0, counter_control[2:0]);
  endtask
  // ticks over a 48-cycle window; timer 0 overflows every fourth cycle,
  // count pin falls 10 times, external clock rises 16 times (keeps /8 phase)
  task automatic t_src(logic [2:0] s, logic [15:0] e);
    wr(0, {4'h0, s, 1'b0});
    wr(1, 8'h40);
    repeat (20) @(posedge core_clk);
    v = 0;
    for (int k = 0; k < 48; k++) begin
      @(posedge core_clk);
      timer0_overflow <= (k % 4 == 0);
      external_count_input <= (k >= 40) || (k % 4 < 2);
      external_clock <= (k < 32) && (k % 2 == 1);
      #1 v = v + count_tick;
    end
    chk("ticks", e, v);
    wr(1, 8'h00);
  endtask
  task automatic t_ovf;
    wr(0, 8'h09);
    wr(1, 8'h40);
    for (int k = 0; k < 70000 && counter_control[7] !== 1'b1; k++) @(posedge core_clk);
    #1 chk("ovf", 1, counter_control[7]);
    chk("ovf irq", 1, counter_array_irq);
    wr(1, 8'h00);
    chk("ovf clr", 0, counter_control[7]);
    chk("ovf irq clr", 0, counter_array_irq);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1;
    @(posedge core_clk);
    #1 t_regs;
    t_flags;
    t_src(0, 4);
    t_src(1, 12);
    t_src(2, 12);
    t_src(3, 10);
    t_src(5, 2);
    t_src(4, 48);
    t_src(6, 0);
    t_src(7, 0);
    t_ovf;
    give_verdict;
  end
  initial begin
    #10000000;
    num_errors++;
    give_verdict;
  end
endmodule
